// file: src/dt_pkg.sv
// Purpose: Constants shared by the dual down-counting timer block.
// Assumes: One system clock; registers reached over a plain strobe port.
// Notes: Offsets are byte addresses inside one timer's chip-select window.

package dt_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DT_OFS_LOAD = 8'h00;
  localparam logic [7:0] DT_OFS_VALUE = 8'h04;
  localparam logic [7:0] DT_OFS_CTRL = 8'h08;
  localparam logic [7:0] DT_OFS_CLEAR = 8'h0c;
  localparam logic [7:0] DT_OFS_STAT = 8'h10;
  localparam logic [7:0] DT_OFS_IEN = 8'h14;

  // ----------------------------------------------------------------
  // Control and status fields
  // ----------------------------------------------------------------
  localparam int DT_CTRL_PRE_LO = 2;
  localparam int DT_CTRL_PRE_HI = 3;
  localparam int DT_CTRL_PERIODIC = 6;
  localparam int DT_CTRL_EN = 7;
  localparam int DT_CTRL_BITS = 8;
  localparam int DT_STAT_ZERO = 0;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  localparam int DT_STAGES_16 = 4;
  localparam int DT_STAGES_256 = 8;

  typedef enum logic [1:0] {
    DT_DIV1 = 2'h0,
    DT_DIV16 = 2'h1,
    DT_DIV256 = 2'h2
  } dt_presc_t;

endpackage

// file: src/dt_timer.sv
// Purpose: One down-counter with its own prescaler.
// Assumes: Load strobe and settings are synchronous to i_clk.
// Notes: Code 2'h3 of the prescale field behaves as divide by 256.

`timescale 1ns/1ps

module dt_timer
  import dt_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst_n, // Synchronised reset, active low
  input wire logic i_load, // Load register written this cycle
  input wire logic [WIDTH-1:0] i_load_val, // Value written
  input wire logic [WIDTH-1:0] i_reload, // Held load register
  input wire logic i_enable, // Count enable
  input wire logic i_periodic, // 1: reload at zero, 0: wrap
  input wire logic [1:0] i_presc, // Prescale select
  output logic [WIDTH-1:0] o_count, // Present count
  output logic o_tick, // Prescaled tick
  output logic o_zero // Pulse: count reached zero
);

  logic [DT_STAGES_256-1:0] pre_q;
  logic [WIDTH-1:0] cnt_q;
  logic zero_q;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_comb begin
    case (i_presc)
      DT_DIV1: o_tick = 1'b1;
      DT_DIV16: o_tick = &pre_q[DT_STAGES_16-1:0];
      default: o_tick = &pre_q;
    endcase
  end

  // Restarting the prescaler on load makes the first period exact
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q <= '0;
    end else if (i_load) begin
      pre_q <= '0;
    end else if (i_enable) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Down-counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (i_load) begin
      cnt_q <= i_load_val;
    end else if (i_enable && o_tick) begin
      if (cnt_q == '0) begin
        cnt_q <= i_periodic ? i_reload : '1;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      zero_q <= 1'b0;
    end else begin
      zero_q <= !i_load && i_enable && o_tick &&
                (cnt_q == WIDTH'(1));
    end
  end

  assign o_count = cnt_q;
  assign o_zero = zero_q;

endmodule

// file: src/dt_top.sv
// Purpose: Dual independent down-counting timers with register port.
// Assumes: Master keeps strobes one cycle long, never both at once.
// Notes: Each timer answers only when its own chip-select is high.

`timescale 1ns/1ps

module dt_top
  import dt_pkg::*;
#(
  parameter int N_TIMERS = 2,
  parameter int WIDTH = 32
) (
  input wire logic i_mclk, // System clock, 50 MHz
  input wire logic i_reset_n, // Asynchronous reset, active low
  input wire logic [N_TIMERS-1:0] i_cs, // Chip-select per timer
  input wire logic [7:0] i_addr, // Byte address in window
  input wire logic [WIDTH-1:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [WIDTH-1:0] o_rdata, // Read data, cycle after
  output logic [N_TIMERS-1:0] o_irq // Interrupt level per timer
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (N_TIMERS < 1) begin : g_bad_n
    $error("dt_top: N_TIMERS must be at least 1");
  end
  if (WIDTH < DT_CTRL_BITS) begin : g_bad_w
    $error("dt_top: WIDTH must cover the control register");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  // Release is synchronised so all timers leave reset on one edge
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic hit_load;
  logic hit_ctrl;
  logic hit_clear;
  logic hit_ien;

  assign hit_load = (i_addr == DT_OFS_LOAD);
  assign hit_ctrl = (i_addr == DT_OFS_CTRL);
  assign hit_clear = (i_addr == DT_OFS_CLEAR);
  assign hit_ien = (i_addr == DT_OFS_IEN);

  // ----------------------------------------------------------------
  // Per-timer state
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] load_q [N_TIMERS];
  logic [DT_CTRL_BITS-1:0] ctrl_q [N_TIMERS];
  logic [WIDTH-1:0] count [N_TIMERS];
  logic [N_TIMERS-1:0] tick;
  logic [N_TIMERS-1:0] zero;
  logic [N_TIMERS-1:0] wr_load;
  logic [N_TIMERS-1:0] wr_clear;
  logic [N_TIMERS-1:0] stat_q;
  logic [N_TIMERS-1:0] stat_d;
  logic [N_TIMERS-1:0] ien_q;
  logic [N_TIMERS-1:0] ien_d;
  logic [N_TIMERS-1:0] irq_q;

  for (genvar i = 0; i < N_TIMERS; i++) begin : g_tmr
    logic wr_sel;

    assign wr_sel = i_wr && i_cs[i];
    assign wr_load[i] = wr_sel && hit_load;
    // Written data is ignored: the write itself is the clear
    assign wr_clear[i] = wr_sel && hit_clear;

    always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
        load_q[i] <= '0;
      end else if (wr_load[i]) begin
        load_q[i] <= i_wdata;
      end
    end

    // Mode, prescale and enable share one control register
    always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
        ctrl_q[i] <= '0;
      end else if (wr_sel && hit_ctrl) begin
        ctrl_q[i] <= i_wdata[DT_CTRL_BITS-1:0];
      end
    end

    // Independent counter per chip-select
    dt_timer #(
      .WIDTH(WIDTH)
    ) u_timer (
      .i_clk(i_mclk),
      .i_rst_n(rst_n),
      .i_load(wr_load[i]),
      .i_load_val(i_wdata),
      .i_reload(load_q[i]),
      .i_enable(ctrl_q[i][DT_CTRL_EN]),
      .i_periodic(ctrl_q[i][DT_CTRL_PERIODIC]),
      .i_presc(ctrl_q[i][DT_CTRL_PRE_HI:DT_CTRL_PRE_LO]),
      .o_count(count[i]),
      .o_tick(tick[i]),
      .o_zero(zero[i])
    );

    // A zero event in the clearing cycle survives the clear
    assign stat_d[i] = zero[i] || (stat_q[i] && !wr_clear[i]);
    assign ien_d[i] = (wr_sel && hit_ien) ?
                      i_wdata[DT_STAT_ZERO] : ien_q[i];

    always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
        stat_q[i] <= 1'b0;
        ien_q[i] <= 1'b1;
        irq_q[i] <= 1'b0;
      end else begin
        stat_q[i] <= stat_d[i];
        ien_q[i] <= ien_d[i];
        irq_q[i] <= stat_d[i] && ien_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] rd_mux;
  logic [WIDTH-1:0] rdata_q;

  // Lowest selected timer answers when several selects are high
  always_comb begin
    rd_mux = '0;
    for (int k = N_TIMERS - 1; k >= 0; k--) begin
      if (i_cs[k]) begin
        case (i_addr)
          DT_OFS_LOAD: rd_mux = load_q[k];
          DT_OFS_VALUE: rd_mux = count[k];
          DT_OFS_CTRL: rd_mux = WIDTH'(ctrl_q[k]);
          DT_OFS_STAT: rd_mux = WIDTH'(stat_q[k]);
          DT_OFS_IEN: rd_mux = WIDTH'(ien_q[k]);
          default: rd_mux = '0;
        endcase
      end
    end
  end

  // Data stand for one cycle only, zero otherwise
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= i_rd ? rd_mux : '0;
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!rst_n);

  logic [WIDTH-1:0] c0;
  logic [WIDTH-1:0] ld0;
  logic [1:0] pre0;
  logic en0;
  logic per0;

  assign c0 = count[0];
  assign ld0 = load_q[0];
  assign pre0 = ctrl_q[0][DT_CTRL_PRE_HI:DT_CTRL_PRE_LO];
  assign en0 = ctrl_q[0][DT_CTRL_EN];
  assign per0 = ctrl_q[0][DT_CTRL_PERIODIC];

  sequence s_load_write;
    i_wr && i_cs[0] && hit_load;
  endsequence

  sequence s_quiet_div16;
    (!tick[0] || pre0 != DT_DIV16) [*8];
  endsequence

  sequence s_zero_then_set;
    zero[0] ##1 stat_q[0];
  endsequence

  property p_load_restart;
    s_load_write |=> (c0 == $past(i_wdata)) && (ld0 == $past(i_wdata));
  endproperty
  a_load_restart: assert property (p_load_restart)
    else $error("count did not restart from written load");

  property p_decrement;
    (en0 && tick[0] && c0 != '0 && !wr_load[0])
      |=> (c0 == $past(c0) - 1'b1);
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("count did not decrement on tick");

  property p_hold_disabled;
    (!en0 && !wr_load[0]) |=> $stable(c0);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled)
    else $error("count moved while disabled");

  property p_freerun_wrap;
    (en0 && !per0 && tick[0] && c0 == '0 && !wr_load[0])
      |=> (c0 == '1);
  endproperty
  a_freerun_wrap: assert property (p_freerun_wrap)
    else $error("free-running counter did not wrap to all ones");

  property p_periodic_reload;
    (en0 && per0 && tick[0] && c0 == '0 && !wr_load[0])
      |=> (c0 == $past(ld0));
  endproperty
  a_periodic_reload: assert property (p_periodic_reload)
    else $error("periodic counter did not reload");

  property p_div16_gap;
    (en0 && pre0 == DT_DIV16 && tick[0] && !wr_load[0])
      ##1 (pre0 == DT_DIV16 && en0) |-> s_quiet_div16;
  endproperty
  a_div16_gap: assert property (p_div16_gap)
    else $error("divide by 16 tick came too early");

  property p_div1_tick;
    (pre0 == DT_DIV1) |-> tick[0];
  endproperty
  a_div1_tick: assert property (p_div1_tick)
    else $error("undivided setting failed to tick");

  property p_zero_irq;
    (s_zero_then_set and (ien_q[0] [*2])) |-> o_irq[0];
  endproperty
  a_zero_irq: assert property (p_zero_irq)
    else $error("zero event did not raise interrupt");

  property p_clear;
    (wr_clear[0] && !zero[0]) |=> !stat_q[0] && !o_irq[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear write left interrupt pending");

  property p_irq_level;
    (o_irq[0] && !wr_clear[0] && !(i_wr && i_cs[0] && hit_ien))
      |=> o_irq[0];
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt dropped without clear");

  property p_read_value;
    (i_rd && i_cs[0] && i_addr == DT_OFS_VALUE) |=> (o_rdata == $past(c0));
  endproperty
  a_read_value: assert property (p_read_value)
    else $error("value read did not return present count");

  property p_rdata_idle;
    !i_rd |=> (o_rdata == '0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data stood without a read");

  property p_zero_event;
    (en0 && tick[0] && c0 == WIDTH'(1) && !wr_load[0]) |=> zero[0];
  endproperty
  a_zero_event: assert property (p_zero_event)
    else $error("reaching zero gave no zero event");

  property p_zero_set;
    zero[0] |=> stat_q[0];
  endproperty
  a_zero_set: assert property (p_zero_set)
    else $error("zero event did not set status");

  property p_stat_sticky;
    (stat_q[0] && !wr_clear[0]) |=> stat_q[0];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky)
    else $error("status dropped without clear");

  // Accesses to the other timer must leave this one alone
  property p_isolated;
    (i_wr && !i_cs[0] && !en0) |=> $stable(c0) && $stable(ld0);
  endproperty
  a_isolated: assert property (p_isolated)
    else $error("write to other timer disturbed timer zero");

endmodule

// file: test/dt_cpu_model.sv
// Purpose: Processor-side model that drives the timer register port.
// Assumes: One-cycle strobes, changed by NBA just after a rising edge.
// Notes: An idle bus shows inverted data, never the last value.

`timescale 1ns/1ps

module dt_cpu_model (
  input wire logic i_clk, // System clock
  input wire logic [31:0] i_rdata, // Read data from the block
  output logic [1:0] o_cs, // Chip-select per timer
  output logic [7:0] o_addr, // Byte address
  output logic [31:0] o_wdata, // Write data
  output logic o_wr, // Write strobe
  output logic o_rd // Read strobe
);
  initial begin
    o_cs = 2'h0;
    o_addr = 8'h00;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // ----------------------------------------------------------------
  // Accesses
  // ----------------------------------------------------------------
  // Load and clear writes come through here; clear data is a don't care
  task automatic write(input logic k, input logic [7:0] a,
                       input logic [31:0] d);
    @(posedge i_clk);
    o_cs <= k ? 2'h2 : 2'h1;
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_cs <= 2'h0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  task automatic read(input logic k, input logic [7:0] a,
                      output logic [31:0] d);
    @(posedge i_clk);
    o_cs <= k ? 2'h2 : 2'h1;
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_cs <= 2'h0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask
endmodule

// file: test/dt_tb_top.sv
// Purpose: Self-checking bench for the dual down-counting timers.
// Assumes: Reset values of zero and interrupt enable one after reset.
// Notes: Prescale checks allow a few cycles of access latency.

`timescale 1ns/1ps

`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end

module dt_tb_top;
  import dt_pkg::*;
  logic i_mclk;
  logic i_reset_n;
  logic [1:0] cs;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [1:0] irq;
  int bad_count;
  int n_tests;

  dt_top #(.N_TIMERS(2), .WIDTH(32)) u_dut (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_cs(cs), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq)
  );

  dt_cpu_model u_cpu (
    .i_clk(i_mclk), .i_rdata(rdata), .o_cs(cs), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd)
  );

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wait_irq(input logic k);
    int n;
    n = 0;
    while (irq[k] !== 1'b1) begin
      @(posedge i_mclk);
      n++;
      if (n > 2000) begin
        bad_count++;
        $display("Error irq wait expected 1 seen %b", irq[k]);
        print_verdict();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] ofs [6];
    logic [31:0] d;
    ofs = '{DT_OFS_LOAD, DT_OFS_VALUE, DT_OFS_CTRL, DT_OFS_STAT,
            DT_OFS_IEN, 8'h18};
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 6; i++) begin
        u_cpu.read(k[0], ofs[i], d);
        `CHK("reset reg", (i == 4) ? 32'h1 : 32'h0, d)
      end
    end
    `CHK("reset irq", 2'h0, irq)
    $display("test reset done");
  endtask

  task automatic t_free();
    logic [31:0] d;
    u_cpu.write(1'b0, DT_OFS_LOAD, 32'h5);
    u_cpu.read(1'b0, DT_OFS_VALUE, d);
    `CHK("loaded value", 32'h5, d)
    u_cpu.read(1'b0, DT_OFS_LOAD, d);
    `CHK("load readback", 32'h5, d)
    repeat (20) @(posedge i_mclk);
    u_cpu.read(1'b0, DT_OFS_VALUE, d);
    `CHK("held value", 32'h5, d)
    u_cpu.write(1'b0, DT_OFS_CTRL, 32'h80);
    wait_irq(1'b0);
    u_cpu.write(1'b0, DT_OFS_CTRL, 32'h0);
    u_cpu.read(1'b0, DT_OFS_STAT, d);
    `CHK("zero status", 32'h1, d)
    u_cpu.read(1'b0, DT_OFS_VALUE, d);
    `CHK("wrapped value", 24'hffffff, d[31:8])
    repeat (10) @(posedge i_mclk);
    `CHK("irq level", 1'b1, irq[0])
    u_cpu.write(1'b0, DT_OFS_CLEAR, 32'h1234);
    u_cpu.read(1'b0, DT_OFS_STAT, d);
    `CHK("cleared status", 32'h0, d)
    `CHK("cleared irq", 1'b0, irq[0])
    $display("test free-running done");
  endtask

  task automatic t_periodic();
    logic [31:0] d;
    u_cpu.write(1'b0, DT_OFS_LOAD, 32'h4);
    u_cpu.write(1'b0, DT_OFS_CTRL, 32'hc0);
    u_cpu.read(1'b0, DT_OFS_CTRL, d);
    `CHK("ctrl readback", 32'hc0, d)
    wait_irq(1'b0);
    u_cpu.write(1'b0, DT_OFS_CTRL, 32'h0);
    u_cpu.read(1'b0, DT_OFS_VALUE, d);
    `CHK("reloaded value", 1'b1, d <= 32'h4)
    u_cpu.write(1'b0, DT_OFS_CLEAR, 32'h0);
    $display("test periodic done");
  endtask

  task automatic t_presc();
    logic [31:0] d;
    int dv [4];
    int dec;
    int ex;
    dv = '{1, 16, 256, 256};
    for (int c = 0; c < 4; c++) begin
      u_cpu.write(1'b0, DT_OFS_LOAD, 32'h10000);
      u_cpu.write(1'b0, DT_OFS_CTRL, 32'h80 | (c << DT_CTRL_PRE_LO));
      repeat (1024) @(posedge i_mclk);
      u_cpu.write(1'b0, DT_OFS_CTRL, 32'h0);
      u_cpu.read(1'b0, DT_OFS_VALUE, d);
      ex = 1024 / dv[c];
      dec = 32'h10000 - int'(d) - ex;
      `CHK("prescaled count", 1'b1, dec >= -2 && dec <= 4)
    end
    $display("test prescale done");
  endtask

  task automatic t_reload();
    logic [31:0] d;
    u_cpu.write(1'b0, DT_OFS_LOAD, 32'h100);
    u_cpu.write(1'b0, DT_OFS_CTRL, 32'h80);
    repeat (50) @(posedge i_mclk);
    u_cpu.write(1'b0, DT_OFS_LOAD, 32'h64);
    u_cpu.read(1'b0, DT_OFS_VALUE, d);
    `CHK("restart value", 1'b1, d <= 32'h64 && d >= 32'h60)
    u_cpu.write(1'b0, DT_OFS_CTRL, 32'h0);
    $display("test restart done");
  endtask

  task automatic t_indep();
    logic [31:0] d;
    u_cpu.write(1'b0, DT_OFS_LOAD, 32'h77);
    u_cpu.write(1'b1, DT_OFS_IEN, 32'h0);
    u_cpu.write(1'b1, DT_OFS_LOAD, 32'h2);
    u_cpu.write(1'b1, DT_OFS_CTRL, 32'h80);
    repeat (30) @(posedge i_mclk);
    u_cpu.read(1'b1, DT_OFS_STAT, d);
    `CHK("timer1 status", 32'h1, d)
    `CHK("masked irq", 2'h0, irq)
    u_cpu.read(1'b0, DT_OFS_VALUE, d);
    `CHK("timer0 untouched", 32'h77, d)
    u_cpu.write(1'b1, DT_OFS_IEN, 32'h1);
    u_cpu.read(1'b1, DT_OFS_IEN, d);
    `CHK("ien readback", 32'h1, d)
    repeat (2) @(posedge i_mclk);
    `CHK("rdata idle", 32'h0, rdata)
    `CHK("unmasked irq", 2'h2, irq)
    u_cpu.write(1'b1, DT_OFS_CLEAR, 32'hffffffff);
    u_cpu.read(1'b1, DT_OFS_STAT, d);
    `CHK("timer1 cleared", 2'h0, irq)
    $display("test independence done");
  endtask

  initial begin
    bad_count = 0;
    n_tests = 0;
    i_reset_n = 1'b0;
    repeat (5) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    t_reset();
    t_free();
    t_periodic();
    t_presc();
    t_reload();
    t_indep();
    print_verdict();
  end
endmodule
